// File: swirq_map.svh
`ifndef SWIRQ_MAP_SVH
`define SWIRQ_MAP_SVH

// register byte offsets on the bus
`define SWIRQ_OFS_INTCTL 12'h000
`define SWIRQ_OFS_PERIPH_ENABLE_1 12'h004
`define SWIRQ_OFS_PERIPH_ENABLE_2 12'h008
`define SWIRQ_OFS_PERIPH_ENABLE_3 12'h00c
`define SWIRQ_OFS_PERIPH_ENABLE_4 12'h010
`define SWIRQ_OFS_PERIPH_REQUEST_FLAGS_1 12'h014
`define SWIRQ_OFS_PERIPH_REQUEST_FLAGS_2 12'h018
`define SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3 12'h01c
`define SWIRQ_OFS_PERIPH_REQUEST_FLAGS_4 12'h020
`define SWIRQ_OFS_STATUS 12'h024
`define SWIRQ_OFS_WDTCTL 12'h028

// interrupt control bit positions
`define SWIRQ_BIT_GIE 7
`define SWIRQ_BIT_PERIPHERAL_IRQ_ENABLE 6
// power status bit positions
`define SWIRQ_BIT_TO 1
`define SWIRQ_BIT_PD 0
// watchdog control bit positions
`define SWIRQ_BIT_WDT_SLEEP_EN 1
`define SWIRQ_BIT_WDT_EN 0

// implemented-bit masks, unimplemented read zero
`define SWIRQ_MASK_FULL 8'hff
`define SWIRQ_MASK_PERIPH_REQUEST_FLAGS_2 8'hef
`define SWIRQ_MASK_INTCTL 8'hff
// hardware-owned bits that software cannot write
`define SWIRQ_RO_PERIPH_REQUEST_FLAGS_1 8'h30
`define SWIRQ_RO_PERIPH_REQUEST_FLAGS_4 8'h30
`define SWIRQ_RO_INTCTL 8'h01

`define SWIRQ_RST_REG 8'h00
`define SWIRQ_RST_STATUS 2'h3
`define SWIRQ_RST_WDTCTL 2'h0

// watchdog count at which the next low-frequency oscillator tick times out
`define SWIRQ_WDT_TICKS 16'h07cf

`endif

// File: swirq_pkg.sv
`default_nettype none
package swirq_pkg;

	typedef enum logic [1:0] {
		SWIRQ_RUN = 2'b00,
		SWIRQ_SLEEP = 2'b01,
		SWIRQ_WAKE = 2'b10
	} swirq_state_t;

	typedef struct packed {
		logic [7:0] periph_request_flags_1;
		logic [7:0] periph_request_flags_2;
		logic [7:0] periph_request_flags_3;
		logic [7:0] periph_request_flags_4;
		logic [7:0] intctl;
	} swirq_src_t;

	typedef struct packed {
		logic [31:0] haddr;
		logic [1:0] htrans;
		logic hwrite;
		logic [2:0] hsize;
		logic hsel;
	} swirq_ahb_t;

endpackage
`default_nettype wire

// File: swirq_sync.sv
`include "swirq_map.svh"
`default_nettype none
module swirq_sync
	import swirq_pkg::*;
#(
	parameter int W = 1
) (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
	} swirq_sync_st_t;

	swirq_sync_st_t st_ff;
	swirq_sync_st_t nxt_st;

	always_comb begin
		nxt_st.meta = async_i;
		nxt_st.sync = st_ff.meta;
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign sync_o = st_ff.sync;
endmodule
`default_nettype wire

// File: swirq_wdt.sv
`include "swirq_map.svh"
`default_nettype none
module swirq_wdt
	import swirq_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic tick_i,
	input wire logic run_i,
	input wire logic clear_i,
	output logic timeout_o
);
	typedef struct packed {
		logic [15:0] count;
		logic tick_d;
		logic timeout;
	} swirq_wdt_st_t;

	swirq_wdt_st_t st_ff;
	swirq_wdt_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick_d = tick_i;
		nxt_st.timeout = 1'b0;
		// count on rising edges of the slow tick only
		if (clear_i || !run_i) begin
			nxt_st.count = 16'h0000;
		end else if (tick_i && !st_ff.tick_d) begin
			if (st_ff.count == `SWIRQ_WDT_TICKS) begin
				nxt_st.count = 16'h0000;
				nxt_st.timeout = 1'b1;
			end else begin
				nxt_st.count = st_ff.count + 16'h0001;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign timeout_o = st_ff.timeout;
endmodule
`default_nettype wire

// File: swirq_top.sv
// Summary of operation
// - unimplemented flag/enable bits read zero
// - sleep only on sleep instruction
// - sleep entry clears watchdog, may keep counting
// - sleep entry clears powered-down, sets timeout
// - cpu clock gated; slow oscillator runs
// - timer1 runs in sleep on slow clocks
// - converter runs in sleep on rc oscillator
// - pins hold pre-sleep drive during sleep
// - sleep affects only the watchdog reset
// - hard resets restart; events resume execution
// - next instruction prefetched during sleep
// - wake needs enable, ignores global enable
// - global enable picks continue or vector
// - every wake-up clears watchdog
// - pending enabled flag makes sleep a no-op
// - flag during sleep wakes immediately
// - powered-down stays set after no-op sleep
// - peripheral sources need peripheral enable
`include "swirq_map.svh"
`default_nettype none
module swirq_top
	import swirq_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic [7:0] evt_periph_request_flags_1_i,
	input wire logic [7:0] evt_periph_request_flags_2_i,
	input wire logic [7:0] evt_periph_request_flags_3_i,
	input wire logic [7:0] evt_periph_request_flags_4_i,
	input wire logic [7:0] evt_intctl_i,
	input wire logic [7:0] hw_level_i,
	input wire logic sleep_instr_i,
	input wire logic low_freq_osc_i,
	input wire logic [1:0] timer1_clk_sel_i,
	input wire logic converter_rc_sel_i,
	input wire logic [7:0] pin_out_i,
	input wire logic [7:0] pin_oe_b_i,
	output logic cpu_clk_en_o,
	output logic prefetch_next_o,
	output logic resume_o,
	output logic vector_isr_o,
	output logic wdt_clear_o,
	output logic wdt_reset_o,
	output logic timer1_run_o,
	output logic converter_run_o,
	output logic [7:0] pin_out_o,
	output logic [7:0] pin_oe_b_o
);
	typedef struct packed {
		swirq_src_t flg;
		logic [7:0] periph_enable_1;
		logic [7:0] periph_enable_2;
		logic [7:0] periph_enable_3;
		logic [7:0] periph_enable_4;
		logic [1:0] status;
		logic [1:0] wdtctl;
		swirq_state_t state;
		logic dp_wr;
		logic dp_rd;
		logic [11:0] dp_addr;
		logic [31:0] rdata;
		logic [7:0] pin_out;
		logic [7:0] pin_oe_b;
		logic cpu_en;
		logic prefetch;
		logic resume;
		logic vector;
		logic wdt_clr;
	} swirq_st_t;

	swirq_st_t st_ff;
	swirq_st_t nxt_st;
	swirq_src_t evt_sync;
	logic slow_tick;
	logic wdt_timeout;
	logic wake_req;
	logic wdt_run;
	logic asleep;

	function automatic logic [7:0] swirq_upd(input logic [7:0] cur, input logic [7:0] evt,
		input logic [7:0] mask, input logic [7:0] ro, input logic [7:0] hw,
		input logic wr, input logic [7:0] wd);
		logic [7:0] v;
		v = cur;
		if (wr) begin
			v = (wd & ~ro) | (cur & ro);
		end
		// hardware set wins over a software clear in the same cycle
		v = (v | evt | (hw & ro)) & ~(ro & ~hw) & mask;
		return v;
	endfunction

	// event inputs come from other peripherals' domains
	swirq_sync #(
		.W(40)
	) u_evt_sync (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.async_i({evt_periph_request_flags_1_i, evt_periph_request_flags_2_i, evt_periph_request_flags_3_i, evt_periph_request_flags_4_i, evt_intctl_i}),
		.sync_o(evt_sync)
	);

	swirq_sync #(
		.W(1)
	) u_tick_sync (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.async_i(low_freq_osc_i),
		.sync_o(slow_tick)
	);

	// watchdog keeps counting asleep only when enabled for sleep
	assign asleep = (st_ff.state == SWIRQ_SLEEP);
	assign wdt_run = st_ff.wdtctl[`SWIRQ_BIT_WDT_EN] &&
		(!asleep || st_ff.wdtctl[`SWIRQ_BIT_WDT_SLEEP_EN]);

	swirq_wdt u_wdt (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.tick_i(slow_tick),
		.run_i(wdt_run),
		.clear_i(st_ff.wdt_clr),
		.timeout_o(wdt_timeout)
	);

	// per-source flag and enable, peripherals behind the peripheral enable
	always_comb begin
		wake_req = |(st_ff.flg.intctl[2:0] & st_ff.flg.intctl[5:3]);
		if (st_ff.flg.intctl[`SWIRQ_BIT_PERIPHERAL_IRQ_ENABLE]) begin
			wake_req = wake_req | (|(st_ff.flg.periph_request_flags_1 & st_ff.periph_enable_1)) | (|(st_ff.flg.periph_request_flags_2 & st_ff.periph_enable_2)) |
				(|(st_ff.flg.periph_request_flags_3 & st_ff.periph_enable_3)) | (|(st_ff.flg.periph_request_flags_4 & st_ff.periph_enable_4));
		end
	end

	always_comb begin
		logic wr_now;
		logic [7:0] wd;
		logic [11:0] a;
		logic global_irq_enable;
		wr_now = st_ff.dp_wr;
		wd = hwdata_i[7:0];
		a = st_ff.dp_addr;
		nxt_st = st_ff;
		global_irq_enable = st_ff.flg.intctl[`SWIRQ_BIT_GIE];

		// single-cycle zero-wait slave; address phase captured here
		nxt_st.dp_wr = hsel_i && hready_i && htrans_i[1] && hwrite_i;
		nxt_st.dp_rd = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
		nxt_st.dp_addr = haddr_i[11:0];

		nxt_st.flg.periph_request_flags_1 = swirq_upd(st_ff.flg.periph_request_flags_1, evt_sync.periph_request_flags_1, `SWIRQ_MASK_FULL, `SWIRQ_RO_PERIPH_REQUEST_FLAGS_1,
			hw_level_i, wr_now && a == `SWIRQ_OFS_PERIPH_REQUEST_FLAGS_1, wd);
		nxt_st.flg.periph_request_flags_2 = swirq_upd(st_ff.flg.periph_request_flags_2, evt_sync.periph_request_flags_2, `SWIRQ_MASK_PERIPH_REQUEST_FLAGS_2, 8'h00,
			hw_level_i, wr_now && a == `SWIRQ_OFS_PERIPH_REQUEST_FLAGS_2, wd);
		nxt_st.flg.periph_request_flags_3 = swirq_upd(st_ff.flg.periph_request_flags_3, evt_sync.periph_request_flags_3, `SWIRQ_MASK_FULL, 8'h00,
			hw_level_i, wr_now && a == `SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3, wd);
		nxt_st.flg.periph_request_flags_4 = swirq_upd(st_ff.flg.periph_request_flags_4, evt_sync.periph_request_flags_4, `SWIRQ_MASK_FULL, `SWIRQ_RO_PERIPH_REQUEST_FLAGS_4,
			hw_level_i, wr_now && a == `SWIRQ_OFS_PERIPH_REQUEST_FLAGS_4, wd);
		// upper control bits are enables, so events touch flags only
		nxt_st.flg.intctl = swirq_upd(st_ff.flg.intctl, evt_sync.intctl & 8'h07, `SWIRQ_MASK_INTCTL,
			`SWIRQ_RO_INTCTL, hw_level_i, wr_now && a == `SWIRQ_OFS_INTCTL, wd);

		if (wr_now) begin
			if (a == `SWIRQ_OFS_PERIPH_ENABLE_1) begin
				nxt_st.periph_enable_1 = wd;
			end else if (a == `SWIRQ_OFS_PERIPH_ENABLE_2) begin
				nxt_st.periph_enable_2 = wd & `SWIRQ_MASK_PERIPH_REQUEST_FLAGS_2;
			end else if (a == `SWIRQ_OFS_PERIPH_ENABLE_3) begin
				nxt_st.periph_enable_3 = wd;
			end else if (a == `SWIRQ_OFS_PERIPH_ENABLE_4) begin
				nxt_st.periph_enable_4 = wd;
			end else if (a == `SWIRQ_OFS_WDTCTL) begin
				nxt_st.wdtctl = wd[1:0];
			end
		end

		nxt_st.rdata = 32'h0000_0000;
		if (nxt_st.dp_rd) begin
			if (haddr_i[11:0] == `SWIRQ_OFS_INTCTL) begin
				nxt_st.rdata = {24'h000000, st_ff.flg.intctl};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_PERIPH_ENABLE_1) begin
				nxt_st.rdata = {24'h000000, st_ff.periph_enable_1};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_PERIPH_ENABLE_2) begin
				nxt_st.rdata = {24'h000000, st_ff.periph_enable_2};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_PERIPH_ENABLE_3) begin
				nxt_st.rdata = {24'h000000, st_ff.periph_enable_3};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_PERIPH_ENABLE_4) begin
				nxt_st.rdata = {24'h000000, st_ff.periph_enable_4};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_PERIPH_REQUEST_FLAGS_1) begin
				nxt_st.rdata = {24'h000000, st_ff.flg.periph_request_flags_1};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_PERIPH_REQUEST_FLAGS_2) begin
				nxt_st.rdata = {24'h000000, st_ff.flg.periph_request_flags_2};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3) begin
				nxt_st.rdata = {24'h000000, st_ff.flg.periph_request_flags_3};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_PERIPH_REQUEST_FLAGS_4) begin
				nxt_st.rdata = {24'h000000, st_ff.flg.periph_request_flags_4};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_STATUS) begin
				nxt_st.rdata = {30'h0, st_ff.status};
			end else if (haddr_i[11:0] == `SWIRQ_OFS_WDTCTL) begin
				nxt_st.rdata = {30'h0, st_ff.wdtctl};
			end
		end

		nxt_st.resume = 1'b0;
		nxt_st.vector = 1'b0;
		nxt_st.wdt_clr = 1'b0;
		nxt_st.prefetch = 1'b0;

		case (st_ff.state)
			SWIRQ_RUN: begin
				nxt_st.cpu_en = 1'b1;
				nxt_st.pin_out = pin_out_i;
				nxt_st.pin_oe_b = pin_oe_b_i;
				if (sleep_instr_i) begin
					nxt_st.prefetch = 1'b1;
					if (!wake_req) begin
						// real sleep entry
						nxt_st.wdt_clr = 1'b1;
						nxt_st.status[`SWIRQ_BIT_PD] = 1'b0;
						nxt_st.status[`SWIRQ_BIT_TO] = 1'b1;
						nxt_st.cpu_en = 1'b0;
						nxt_st.state = SWIRQ_SLEEP;
					end
					// else no-op: status and watchdog untouched
				end
			end
			SWIRQ_SLEEP: begin
				nxt_st.cpu_en = 1'b0;
				// pins frozen at the values captured before entry
				if (wake_req || wdt_timeout) begin
					nxt_st.wdt_clr = 1'b1;
					nxt_st.state = SWIRQ_WAKE;
				end
			end
			SWIRQ_WAKE: begin
				nxt_st.cpu_en = 1'b1;
				nxt_st.resume = 1'b1;
				nxt_st.vector = global_irq_enable && wake_req;
				if (wdt_timeout || !wake_req) begin
					nxt_st.status[`SWIRQ_BIT_TO] = st_ff.status[`SWIRQ_BIT_TO];
				end
				nxt_st.state = SWIRQ_RUN;
			end
			default: begin
				nxt_st.state = SWIRQ_RUN;
			end
		endcase
		// watchdog expiry while asleep is a wake; asleep or awake it clears time-out
		if (wdt_timeout && st_ff.state != SWIRQ_SLEEP) begin
			nxt_st.status[`SWIRQ_BIT_TO] = 1'b0;
		end
		if (wdt_timeout && st_ff.state == SWIRQ_SLEEP) begin
			nxt_st.status[`SWIRQ_BIT_TO] = 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_ff <= '0;
			st_ff.status <= `SWIRQ_RST_STATUS;
			st_ff.wdtctl <= `SWIRQ_RST_WDTCTL;
			st_ff.state <= SWIRQ_RUN;
			st_ff.cpu_en <= 1'b1;
			st_ff.pin_oe_b <= 8'hff;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign hrdata_o = st_ff.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
	assign cpu_clk_en_o = st_ff.cpu_en;
	assign prefetch_next_o = st_ff.prefetch;
	assign resume_o = st_ff.resume;
	assign vector_isr_o = st_ff.vector;
	assign wdt_clear_o = st_ff.wdt_clr;
	// only the watchdog resets while awake; asleep it wakes instead
	assign wdt_reset_o = wdt_timeout && !asleep;
	// slow-clocked peripherals keep running whatever the sleep state
	assign timer1_run_o = (timer1_clk_sel_i != 2'b00);
	assign converter_run_o = converter_rc_sel_i;
	assign pin_out_o = st_ff.pin_out;
	assign pin_oe_b_o = st_ff.pin_oe_b;
endmodule
`default_nettype wire

// File: swirq_checker.sv
`default_nettype none
module swirq_checker
	import swirq_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic sleep_instr_i,
	input wire logic [1:0] timer1_clk_sel_i,
	input wire logic converter_rc_sel_i,
	input wire logic cpu_clk_en_o,
	input wire logic prefetch_next_o,
	input wire logic resume_o,
	input wire logic vector_isr_o,
	input wire logic wdt_clear_o,
	input wire logic timer1_run_o,
	input wire logic converter_run_o,
	input wire logic [7:0] pin_out_o,
	input wire logic [7:0] pin_oe_b_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence s_resume;
		cpu_clk_en_o && resume_o;
	endsequence

	a_sleep_cause: assert property ($fell(cpu_clk_en_o) |-> $past(sleep_instr_i))
		else $error("cpu clock stopped without sleep request");
	a_sleep_prefetch: assert property (sleep_instr_i |=> prefetch_next_o)
		else $error("no prefetch after sleep request");
	a_entry_wdt_clear: assert property ($fell(cpu_clk_en_o) |-> wdt_clear_o)
		else $error("watchdog not cleared on sleep entry");
	// both cycles asleep, so the entry edge itself is excluded
	a_pins_held: assert property (!cpu_clk_en_o && !$past(cpu_clk_en_o) |-> $stable(pin_out_o) && $stable(pin_oe_b_o))
		else $error("pin drive changed while asleep");
	a_timer1_run: assert property (timer1_run_o == (timer1_clk_sel_i != 2'h0))
		else $error("timer1 run mismatch");
	a_conv_run: assert property (converter_run_o == converter_rc_sel_i)
		else $error("converter run mismatch");
	a_wake_clear: assert property (wdt_clear_o && !cpu_clk_en_o && !$past(cpu_clk_en_o) |=> s_resume)
		else $error("wake clear not followed by resume");
	a_resume_clock: assert property ($rose(cpu_clk_en_o) |-> resume_o)
		else $error("clock restarted without resume");
	a_vector_resume: assert property (vector_isr_o |-> resume_o)
		else $error("vector without resume");
endmodule

bind swirq_top swirq_checker u_swirq_checker (.clock_i, .rst_b_i, .sleep_instr_i, .timer1_clk_sel_i,
	.converter_rc_sel_i, .cpu_clk_en_o, .prefetch_next_o, .resume_o, .vector_isr_o, .wdt_clear_o,
	.timer1_run_o, .converter_run_o, .pin_out_o, .pin_oe_b_o);
`default_nettype wire

// File: swirq_core_model.sv
`default_nettype none
module swirq_core_model
	import swirq_pkg::*;
(
	input wire logic clock_i,
	output logic sleep_instr_o,
	output swirq_src_t evt_o,
	output logic low_freq_osc_o,
	output logic [7:0] pin_out_o,
	output logic [7:0] pin_oe_b_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] div;
	initial begin
		sleep_instr_o = 1'b0;
		evt_o = '0;
		div = 5'h00;
	end
	// slow oscillator runs free, also in sleep
	always @(posedge clock_i) begin
		div <= div + 5'h01;
	end
	assign low_freq_osc_o = div[4];
	// core drive changes every cycle so a missed freeze shows
	assign pin_out_o = {div, 3'h5};
	assign pin_oe_b_o = {3'h2, div};

	task sleep;
		@(posedge clock_i);
		sleep_instr_o <= 1'b1;
		@(posedge clock_i);
		sleep_instr_o <= 1'b0;
	endtask

	task fire(input swirq_src_t e);
		@(posedge clock_i);
		evt_o <= e;
		@(posedge clock_i);
		evt_o <= '0;
	endtask
endmodule
`default_nettype wire

// File: sleep_wake_and_irq_flags_test.sv
`default_nettype none
`include "swirq_map.svh"
module sleep_wake_and_irq_flags_test
	import swirq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic hwrite = 1'b0;
	logic conv_sel = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [1:0] t1sel = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata_o;
	logic hreadyout_o, hresp_o, cpu_clk_en_o, prefetch_next_o, resume_o, vector_isr_o;
	logic wdt_clear_o, timer1_run_o, converter_run_o, sleep_i, lfo, wdt_rst;
	logic [7:0] pin_i, poe_i, pin_o, poe_o;
	swirq_src_t evt;
	int err_total = 0;
	int n_tests = 0;

	swirq_top u_swirq_top (.clock_i, .rst_b_i, .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout_o), .hrdata_o,
		.hreadyout_o, .hresp_o, .evt_periph_request_flags_1_i(evt.periph_request_flags_1), .evt_periph_request_flags_2_i(evt.periph_request_flags_2), .evt_periph_request_flags_3_i(evt.periph_request_flags_3),
		.evt_periph_request_flags_4_i(evt.periph_request_flags_4), .evt_intctl_i(evt.intctl), .hw_level_i(8'h00), .sleep_instr_i(sleep_i),
		.low_freq_osc_i(lfo), .timer1_clk_sel_i(t1sel), .converter_rc_sel_i(conv_sel), .pin_out_i(pin_i),
		.pin_oe_b_i(poe_i), .cpu_clk_en_o, .prefetch_next_o, .resume_o, .vector_isr_o, .wdt_clear_o,
		.wdt_reset_o(wdt_rst), .timer1_run_o, .converter_run_o, .pin_out_o(pin_o), .pin_oe_b_o(poe_o));

	swirq_core_model u_core (.clock_i, .sleep_instr_o(sleep_i), .evt_o(evt), .low_freq_osc_o(lfo),
		.pin_out_o(pin_i), .pin_oe_b_o(poe_i));

	initial begin
		forever #20 clock_i = ~clock_i;
	end

	task test_done;
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task rdy;
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_total++;
			test_done;
		end
	endtask

	task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		htrans <= 2'h2;
		haddr <= {20'h0, a};
		hwrite <= w;
		rdy;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy;
		rd = hrdata_o;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		xfer(1'b1, a, d, x);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] x;
		xfer(1'b0, a, 32'h0, x);
		chk(x, e);
	endtask

	// resume is a pulse, so poll it just after each edge
	task wake(input logic vec, input int lim);
		int n;
		n = 0;
		while (resume_o !== 1'b1 && n < lim) begin
			@(posedge clock_i);
			#1;
			n++;
		end
		if (n >= lim) begin
			err_total++;
			test_done;
		end
		chk(vector_isr_o, vec);
	endtask

	initial begin
		repeat (8) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 9; i++) rd(12'(i * 4), 32'h0);
		rd(`SWIRQ_OFS_STATUS, 32'h3);
		rd(12'h0fc, 32'h0);
		wr(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_2, 32'hff);
		rd(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_2, 32'hef);
		wr(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_2, 32'h0);
		rd(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_2, 32'h0);
		u_core.fire('{periph_request_flags_3: 8'h81, default: 8'h00});
		repeat (4) @(posedge clock_i);
		rd(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3, 32'h81);
		wr(`SWIRQ_OFS_PERIPH_ENABLE_3, 32'h01);
		wr(`SWIRQ_OFS_INTCTL, 32'h40);
		u_core.sleep;
		repeat (3) @(posedge clock_i);
		chk(cpu_clk_en_o, 1'b1);
		rd(`SWIRQ_OFS_STATUS, 32'h3);
		wr(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3, 32'h0);
		rd(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3, 32'h0);
		u_core.sleep;
		repeat (2) @(posedge clock_i);
		chk(cpu_clk_en_o, 1'b0);
		rd(`SWIRQ_OFS_STATUS, 32'h2);
		u_core.fire('{periph_request_flags_3: 8'h01, default: 8'h00});
		wake(1'b0, 64);
		rd(`SWIRQ_OFS_STATUS, 32'h2);
		wr(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3, 32'h0);
		wr(`SWIRQ_OFS_INTCTL, 32'hc0);
		u_core.sleep;
		u_core.fire('{periph_request_flags_3: 8'h01, default: 8'h00});
		wake(1'b1, 64);
		wr(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3, 32'h0);
		wr(`SWIRQ_OFS_INTCTL, 32'h80);
		u_core.sleep;
		u_core.fire('{periph_request_flags_3: 8'h01, default: 8'h00});
		repeat (20) @(posedge clock_i);
		chk(cpu_clk_en_o, 1'b0);
		wr(`SWIRQ_OFS_INTCTL, 32'h40);
		wake(1'b0, 64);
		// watchdog kept running in sleep must wake without a reset
		wr(`SWIRQ_OFS_PERIPH_REQUEST_FLAGS_3, 32'h0);
		wr(`SWIRQ_OFS_WDTCTL, 32'h3);
		rd(`SWIRQ_OFS_WDTCTL, 32'h3);
		u_core.sleep;
		wake(1'b0, 70000);
		chk(wdt_rst, 1'b0);
		rd(`SWIRQ_OFS_STATUS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			t1sel <= 2'(i);
			conv_sel <= i[0];
			@(posedge clock_i);
			#1;
			chk(timer1_run_o, i != 0);
			chk(converter_run_o, i[0]);
		end
		test_done;
	end

	initial begin
		#4000000;
		err_total++;
		test_done;
	end
endmodule
`default_nettype wire
